/* mac_tx_status_rx_filter.sv */
// Purpose: transmit outcome capture and receive acceptance filter
// Assumes: event inputs synchronous to i_clk, one-cycle pulses
// Notes: multicast hash result supplied from outside as i_rx_hash_hit
// Notes: bus writes land at the edge that samples pready high
//
// Design decisions made here: the address map and register access over APB.
`timescale 1ns/1ns
`default_nettype none
module mac_tx_status_rx_filter
    import mac_txrx_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [11:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    output logic [31:0] o_prdata,
    output logic o_pready,
    output logic o_pslverr,
    input wire logic i_tx_data_start,
    input wire logic i_tx_end,
    input wire logic i_collision,
    input wire logic i_carrier,
    input wire logic i_fifo_empty_nobus,
    input wire logic i_heartbeat,
    input wire logic i_rx_end,
    input wire logic [47:0] i_rx_dest,
    input wire logic i_rx_crc_err,
    input wire logic i_rx_align_err,
    input wire logic [10:0] i_rx_len,
    input wire logic i_rx_hash_hit,
    output logic o_tx_busy,
    output logic o_tx_abort,
    output logic o_tx_retry,
    output logic o_rx_accept,
    output logic o_rx_store
);
    // transmit sequencer state
    tx_state_t st_r;
    tx_state_t st_nxt;
    // transmit outcome flags, no reset: undefined until the first send
    logic [7:0] status_r;
    logic [7:0] status_nxt;
    // receive filter configuration, bits 6 and 7 always zero
    logic [7:0] rcfg_r;
    // attempt count of the current frame, first attempt counts as one
    logic [4:0] attempts_r;
    logic [4:0] attempts_nxt;
    // station address, byte 0 in the low bits
    logic [47:0] station_r;
    // frames recognised while in check-only mode
    logic [15:0] missed_r;
    // cycles since the attempt started or since the frame ended
    logic [15:0] tmr_r;
    logic [15:0] tmr_nxt;
    // preamble done, carrier is watched from here on
    logic in_data_r;
    logic in_data_nxt;
    // heartbeat seen inside the current gap window
    logic hb_seen_r;
    logic hb_seen_nxt;
    // registered copies behind the outputs
    logic acc_r;
    logic store_r;
    logic abort_r;
    logic retry_r;
    logic ready_r;
    logic slverr_r;
    logic [31:0] rdata_r;

    // register select, one compare per offset
    function automatic logic addr_is(input logic [11:0] a, input logic [11:0] ofs);
        return (a == ofs);
    endfunction

    // saturating step, so a stuck frame never wraps back into a window
    function automatic logic [15:0] sat_inc(input logic [15:0] v);
        return (v == 16'hFFFF) ? v : v + 16'h0001;
    endfunction

    // apb decode: one wait state, then pready for one cycle
    // the first access cycle raises pready; a write lands at the edge that samples it
    wire logic acc_ph = i_psel && i_penable && !ready_r;
    wire logic wr = i_psel && i_penable && ready_r && i_pwrite;
    wire logic hit_ts = addr_is(i_paddr, TX_STATUS_OFS);
    wire logic hit_rc = addr_is(i_paddr, RX_CFG_OFS);
    wire logic hit_cc = addr_is(i_paddr, COLL_CNT_OFS);
    wire logic hit_sl = addr_is(i_paddr, STATION_LO_OFS);
    wire logic hit_sh = addr_is(i_paddr, STATION_HI_OFS);
    wire logic hit_mc = addr_is(i_paddr, MISSED_CNT_OFS);
    wire logic hit_tc = addr_is(i_paddr, TX_CTRL_OFS);
    // unmapped offsets answer with an error and zero data
    wire logic mapped = hit_ts | hit_rc | hit_cc | hit_sl | hit_sh | hit_mc | hit_tc;
    // writing bit 0 of the control word starts the next transmission
    // a start while busy is dropped, so the frame in flight keeps its status
    wire logic tx_go = wr && hit_tc && i_pwdata[0] && (st_r == TX_IDLE);

    // read data mux, unused upper bits read as zero
    wire logic [31:0] rd_mux =
        hit_ts ? {24'h000000, status_r} :
        hit_rc ? {24'h000000, rcfg_r} :
        hit_cc ? {27'h0000000, attempts_r} :
        hit_sl ? station_r[31:0] :
        hit_sh ? {16'h0000, station_r[47:32]} :
        hit_mc ? {16'h0000, missed_r} :
        hit_tc ? {31'h00000000, o_tx_busy} : 32'h00000000;

    // receive filter
    // destination byte 0 arrives first, its low bit is the group bit
    wire logic is_group = i_rx_dest[0];
    // all ones is broadcast, which is also a group address
    wire logic is_bcast = &i_rx_dest;
    // exact compare against the station address
    wire logic own_match = (i_rx_dest == station_r);
    // crc and alignment errors are treated alike
    wire logic rx_err = i_rx_crc_err | i_rx_align_err;
    // length counted in bytes, 64 is the shortest legal frame
    wire logic runt = (i_rx_len < 11'(MIN_FRAME_BYTES));

    wire logic ok_bc = is_bcast && rcfg_r[RC_BCAST];
    // multicast gate
    // the hash lookup sits outside; broadcast is kept off this path
    wire logic ok_mc = is_group && !is_bcast && rcfg_r[RC_MCAST] && i_rx_hash_hit;
    wire logic ok_ph = !is_group && (rcfg_r[RC_PROM] || own_match);
    wire logic addr_ok = ok_bc | ok_mc | ok_ph;
    wire logic err_ok = !rx_err || rcfg_r[RC_ERR];
    wire logic len_ok = !runt || rcfg_r[RC_RUNT];
    wire logic rx_ok = addr_ok && err_ok && len_ok;

    // transmit outcome sequencing
    // one timer serves both windows: from attempt start for the slot,
    // from frame end for the heartbeat gap
    wire logic slot_over = (tmr_r >= 16'(SLOT_CYC));
    wire logic hb_window = (tmr_r < 16'(HB_CYC));
    // named events, so each branch below reads as the behaviour it follows
    wire logic carrier_gone = in_data_r && !i_carrier;
    wire logic tries_spent = (attempts_r >= MAX_ATTEMPTS);
    wire logic hb_in_window = i_heartbeat && hb_window;
    // next attempt number, only used when a retry is allowed
    wire logic [4:0] attempts_inc = attempts_r + 5'h01;

    // next-state logic; flags only go from zero to one inside a send
    always_comb begin
        // defaults: hold all state, let the timer run
        st_nxt = st_r;
        status_nxt = status_r;
        attempts_nxt = attempts_r;
        tmr_nxt = sat_inc(tmr_r);
        in_data_nxt = in_data_r;
        hb_seen_nxt = hb_seen_r;
        case (st_r)
            // idle: wait for software to start a frame
            TX_IDLE: begin
                if (tx_go) begin
                    status_nxt = 8'h00;
                    attempts_nxt = 5'h01;
                    tmr_nxt = 16'h0000;
                    in_data_nxt = 1'b0;
                    st_nxt = TX_SEND;
                end
            end
            // send: medium events, underrun ranks first
            // each branch sets only its own flags; a collision can set TS_COL, TS_LATE_COL and TS_ABORT_EXCESS
            TX_SEND: begin
                if (i_tx_data_start) begin
                    // preamble and sync done, carrier watch begins
                    in_data_nxt = 1'b1;
                end
                // carrier loss flagged only
                // the send carries on; a lost carrier is reported, never acted on
                if (carrier_gone) begin
                    status_nxt[TS_CARRIER_LOST] = 1'b1;
                end
                if (i_fifo_empty_nobus) begin
                    status_nxt[TS_UNDERRUN] = 1'b1;
                    st_nxt = TX_IDLE;
                end else if (i_collision) begin
                    status_nxt[TS_COL] = 1'b1;
                    if (slot_over) begin
                        status_nxt[TS_LATE_COL] = 1'b1;
                    end
                    if (tries_spent) begin
                        status_nxt[TS_ABORT_EXCESS] = 1'b1;
                        st_nxt = TX_IDLE;
                    end else begin
                        // next attempt restarts the slot timer and the carrier watch
                        attempts_nxt = attempts_inc;
                        tmr_nxt = 16'h0000;
                        in_data_nxt = 1'b0;
                    end
                end else if (i_tx_end) begin
                    // ok only without abort or underrun
                    // both abort paths leave this state first, so ok never joins them
                    status_nxt[TS_OK] = 1'b1;
                    tmr_nxt = 16'h0000;
                    hb_seen_nxt = 1'b0;
                    st_nxt = TX_GAP;
                end
            end
            // gap: listen for the transceiver heartbeat
            TX_GAP: begin
                if (hb_in_window) begin
                    hb_seen_nxt = 1'b1;
                end
                // heartbeat window check
                // a pulse on the last window cycle is still seen one cycle later
                if (!hb_window) begin
                    status_nxt[TS_HB_FAIL] = !hb_seen_r;
                    st_nxt = TX_IDLE;
                end
            end
            default: begin
                // unused code, recover to idle
                st_nxt = TX_IDLE;
            end
        endcase
    end

    // status holds no reset value, left as is
    // no bus write path to status
    // only the sequencer feeds these flags; a bus write cannot reach them
    always_ff @(posedge i_clk) begin
        status_r <= status_nxt;
    end

    // control state
    // busy comes from the next state so it lines up with the state register
    // abort and retry are one-cycle pulses marking how an attempt ended
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            st_r <= TX_IDLE;
            attempts_r <= 5'h00;
            tmr_r <= 16'h0000;
            in_data_r <= 1'b0;
            hb_seen_r <= 1'b0;
            o_tx_busy <= 1'b0;
            abort_r <= 1'b0;
            retry_r <= 1'b0;
        end else begin
            st_r <= st_nxt;
            attempts_r <= attempts_nxt;
            tmr_r <= tmr_nxt;
            in_data_r <= in_data_nxt;
            hb_seen_r <= hb_seen_nxt;
            o_tx_busy <= (st_nxt == TX_SEND);
            abort_r <= (st_r == TX_SEND) && (st_nxt == TX_IDLE);
            retry_r <= (st_r == TX_SEND) && (st_nxt == TX_SEND) && i_collision;
        end
    end

    // registers written by software; bits 6 and 7 kept zero regardless
    // masking here keeps a careless write from ever reaching the reserved bits
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            rcfg_r <= RX_CFG_RST;
            station_r <= 48'h000000000000;
        end else if (wr) begin
            if (hit_rc) begin
                rcfg_r <= i_pwdata[7:0] & RX_CFG_WMASK;
            end
            if (hit_sl) begin
                station_r[31:0] <= i_pwdata;
            end
            if (hit_sh) begin
                station_r[47:32] <= i_pwdata[15:0];
            end
        end
    end

    // a frame that passes every gate, qualified by its end strobe
    wire logic frame_ok = i_rx_end && rx_ok;

    // receive decision outputs and monitor-mode tally
    // the tally wraps; software is expected to read it often enough
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            acc_r <= 1'b0;
            store_r <= 1'b0;
            missed_r <= 16'h0000;
        end else begin
            acc_r <= frame_ok;
            // monitor mode: check, count, never store
            store_r <= frame_ok && !rcfg_r[RC_CHECK_ONLY];
            if (frame_ok && rcfg_r[RC_CHECK_ONLY]) begin
                missed_r <= missed_r + 16'h0001;
            end
        end
    end

    // apb response
    // read data is latched in the first access cycle and stands with pready
    // error and data both drop back after one cycle
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            ready_r <= 1'b0;
            slverr_r <= 1'b0;
            rdata_r <= 32'h00000000;
        end else begin
            ready_r <= acc_ph;
            slverr_r <= acc_ph && !mapped;
            rdata_r <= (acc_ph && !i_pwrite) ? rd_mux : 32'h00000000;
        end
    end


    // every output is a flop copy
    assign o_pready = ready_r;
    assign o_pslverr = slverr_r;
    assign o_prdata = rdata_r;
    assign o_tx_abort = abort_r;
    assign o_tx_retry = retry_r;
    assign o_rx_accept = acc_r;
    assign o_rx_store = store_r;
endmodule // mac_tx_status_rx_filter
`default_nettype wire

/* mac_txrx_pkg.sv */
// Purpose: constants for transmit outcome status and receive filter block
// Assumes: apb with 32-bit data, one aligned word per register
// Notes: register offsets below are chosen locally
package mac_txrx_pkg;
    localparam logic [11:0] TX_STATUS_OFS = 12'h000;
    localparam logic [11:0] RX_CFG_OFS = 12'h004;
    localparam logic [11:0] COLL_CNT_OFS = 12'h008;
    localparam logic [11:0] STATION_LO_OFS = 12'h00C;
    localparam logic [11:0] STATION_HI_OFS = 12'h010;
    localparam logic [11:0] MISSED_CNT_OFS = 12'h014;
    localparam logic [11:0] TX_CTRL_OFS = 12'h018;
    // transmit status bits
    localparam int TS_OK = 0;
    localparam int TS_COL = 2;
    localparam int TS_ABORT_EXCESS = 3;
    localparam int TS_CARRIER_LOST = 4;
    localparam int TS_UNDERRUN = 5;
    localparam int TS_HB_FAIL = 6;
    localparam int TS_LATE_COL = 7;
    // receive config bits
    localparam int RC_ERR = 0;
    localparam int RC_RUNT = 1;
    localparam int RC_BCAST = 2;
    localparam int RC_MCAST = 3;
    localparam int RC_PROM = 4;
    localparam int RC_CHECK_ONLY = 5;
    localparam logic [7:0] RX_CFG_RST = 8'h00;
    localparam logic [7:0] RX_CFG_WMASK = 8'h3F;
    localparam logic [4:0] MAX_ATTEMPTS = 5'h10;
    localparam int MIN_FRAME_BYTES = 64;
    localparam int CLK_MHZ = 10;
    // times in tenths of a microsecond
    localparam int HB_WIN_X10US = 64;
    localparam int SLOT_X10US = 512;
    localparam int HB_CYC = HB_WIN_X10US * CLK_MHZ / 10;
    localparam int SLOT_CYC = SLOT_X10US * CLK_MHZ / 10;
    typedef enum logic [1:0] {
        TX_IDLE = 2'b00,
        TX_SEND = 2'b01,
        TX_GAP = 2'b10
    } tx_state_t;
endpackage

/* mac_txrx_chk_assertions.sv */
// Purpose: port-level checks for the transmit status and receive filter block
// Assumes: one clock, asynchronous active-high reset
// Notes: sees top ports only, so config-dependent filtering is left to the bench
`timescale 1ns/1ns
`default_nettype none
module mac_txrx_chk (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic [31:0] o_prdata,
    input wire logic o_pready,
    input wire logic o_pslverr,
    input wire logic i_tx_end,
    input wire logic i_collision,
    input wire logic i_carrier,
    input wire logic i_fifo_empty_nobus,
    input wire logic i_rx_end,
    input wire logic o_tx_busy,
    input wire logic o_tx_abort,
    input wire logic o_tx_retry,
    input wire logic o_rx_accept,
    input wire logic o_rx_store
);
    default clocking dcb @(posedge i_clk); endclocking
    default disable iff (i_rst);
    // bus answers after exactly one wait state, as a single pulse
    a_ready_one_wait: assert property (i_psel && i_penable && !o_pready |=> o_pready)
        else $error("ready late");
    a_ready_pulse: assert property (o_pready |=> !o_pready)
        else $error("ready held");
    a_slverr_zero: assert property (o_pslverr |-> o_pready && o_prdata == 32'h0)
        else $error("error read not zero");
    // carrier loss alone must never stop the send
    a_carrier_keeps: assert property (o_tx_busy && !i_carrier && !i_fifo_empty_nobus
        && !i_collision && !i_tx_end |=> o_tx_busy)
        else $error("carrier loss stopped send");
    a_underrun_abort: assert property (o_tx_busy && i_fifo_empty_nobus |=>
        o_tx_abort && !o_tx_busy)
        else $error("underrun not aborted");
    a_collision_retry: assert property (o_tx_busy && i_collision && !i_fifo_empty_nobus
        |=> o_tx_retry ^ o_tx_abort)
        else $error("collision not rescheduled");
    a_accept_after_end: assert property (o_rx_accept |-> $past(i_rx_end))
        else $error("accept without frame");
    a_store_needs_accept: assert property (o_rx_store |-> o_rx_accept)
        else $error("stored a rejected frame");
    c_abort: cover property (o_tx_abort);
    c_store: cover property (o_rx_store);
    c_slverr: cover property (o_pslverr);
endmodule // mac_txrx_chk
bind mac_tx_status_rx_filter mac_txrx_chk u_chk (.i_clk, .i_rst, .i_psel, .i_penable,
    .o_prdata, .o_pready, .o_pslverr, .i_tx_end, .i_collision, .i_carrier,
    .i_fifo_empty_nobus, .i_rx_end, .o_tx_busy, .o_tx_abort, .o_tx_retry,
    .o_rx_accept, .o_rx_store);
`default_nettype wire

/* medium_model.sv */
// Purpose: medium and transceiver stand-in for transmit tests
// Assumes: carrier echoes our own send
// Notes: heartbeat pulse can be withheld to provoke a failure flag
`timescale 1ns/1ns
`default_nettype none
module medium_model (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_tx_busy,
    input wire logic i_drop_carrier,
    input wire logic i_hb_on,
    output logic o_carrier,
    output logic o_heartbeat
);
    logic [7:0] gap_r;
    assign o_carrier = i_tx_busy && !i_drop_carrier;
    assign o_heartbeat = i_hb_on && gap_r == 8'h0A;
    // gap count saturates so the pulse fires once per gap
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            gap_r <= 8'hFF;
        end else if (i_tx_busy) begin
            gap_r <= 8'h00;
        end else if (gap_r != 8'hFF) begin
            gap_r <= gap_r + 8'h01;
        end
    end
endmodule // medium_model
`default_nettype wire

/* mac_tx_status_rx_filter_tb_top.sv */
// Purpose: self-checking bench for transmit status and receive filter
// Assumes: apb master here, medium stand-in in medium_model
// Notes: frames and configs come from a fixed-seed lfsr
`timescale 1ns/1ns
`default_nettype none
module mac_tx_status_rx_filter_tb_top;
    import mac_txrx_pkg::*;
    logic i_clk = 1'b0, i_rst = 1'b1, i_psel = 1'b0, i_penable = 1'b0, i_pwrite = 1'b0;
    logic [11:0] i_paddr = 12'h000;
    logic [31:0] i_pwdata = 32'h0, o_prdata, q, r = 32'h6B1BEEF7;
    logic o_pready, o_pslverr, e, o_tx_busy, o_tx_abort, o_tx_retry, o_rx_accept, o_rx_store;
    logic i_carrier, i_heartbeat, drop = 1'b0, hb_on = 1'b0, i_rx_end = 1'b0;
    logic i_rx_crc_err = 1'b0, i_rx_align_err = 1'b0, i_rx_hash_hit = 1'b0;
    logic [3:0] ev = 4'h0;
    logic [47:0] i_rx_dest = 48'h0, stn;
    logic [10:0] i_rx_len = 11'h040;
    logic [7:0] cfg;
    int n_fail = 0, n_compared = 0, tally = 0;
    wire logic i_tx_data_start = ev[0];
    wire logic i_tx_end = ev[1];
    wire logic i_collision = ev[2];
    wire logic i_fifo_empty_nobus = ev[3];
    mac_tx_status_rx_filter u_dut (.*);
    medium_model u_medium (.i_clk, .i_rst, .i_tx_busy(o_tx_busy), .i_drop_carrier(drop),
        .i_hb_on(hb_on), .o_carrier(i_carrier), .o_heartbeat(i_heartbeat));
    always #50 i_clk = ~i_clk;
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    // expected {store, accept} for the frame now on the inputs
    function automatic logic [1:0] want(input logic [7:0] c);
        logic ok;
        ok = i_rx_dest == 48'hFFFFFFFFFFFF ? c[RC_BCAST] : i_rx_dest[0] ?
            c[RC_MCAST] & i_rx_hash_hit : c[RC_PROM] | i_rx_dest == stn;
        ok = ok & (c[RC_ERR] | !(i_rx_crc_err | i_rx_align_err)) & (c[RC_RUNT] | i_rx_len > 11'h03F);
        return {ok & !c[RC_CHECK_ONLY], ok};
    endfunction
    task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] got);
        n_compared++;
        if (got !== x) begin
            n_fail++;
            $display("BAD %s exp %h got %h", nm, x, got);
        end
    endtask
    task automatic tally_and_finish();
        if (n_fail == 0 && n_compared > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    // holds the request until the edge that samples pready high, takes data there
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge i_clk);
        i_psel <= 1'b1;
        i_penable <= 1'b0;
        i_pwrite <= w;
        i_paddr <= a;
        i_pwdata <= d;
        @(posedge i_clk);
        i_penable <= 1'b1;
        do begin
            @(posedge i_clk);
            n++;
        end while (o_pready !== 1'b1 && n < 20);
        if (o_pready !== 1'b1) begin
            n_fail++;
            tally_and_finish();
        end
        q = o_prdata;
        e = o_pslverr;
        i_psel <= 1'b0;
        i_penable <= 1'b0;
    endtask
    task automatic rchk(input logic [11:0] a, input logic [31:0] m, input logic [31:0] x,
        input string nm);
        apb(1'b0, a, 32'h0);
        chk(nm, x, q & m);
    endtask
    task automatic pulse(input logic [3:0] m);
        @(posedge i_clk);
        ev <= m;
        @(posedge i_clk);
        ev <= 4'h0;
    endtask
    // waits for the 64-cycle heartbeat window to close before reading status
    // status read once after every transmission
    task automatic txst(input logic [7:0] m, input logic [7:0] x, input string nm);
        repeat (80) @(posedge i_clk);
        rchk(TX_STATUS_OFS, {24'h0, m}, {24'h0, x}, nm);
    endtask
    initial begin
        repeat (6) @(posedge i_clk);
        i_rst <= 1'b0;
        apb(1'b1, RX_CFG_OFS, r | 32'hC0);
        rchk(RX_CFG_OFS, 32'hFF, r & {24'h0, RX_CFG_WMASK}, "rx_cfg");
        apb(1'b0, 12'hFFC, 32'h0);
        chk("unmapped", 32'h1, {31'h0, e});
        hb_on <= 1'b1;
        apb(1'b1, TX_CTRL_OFS, 32'h1);
        pulse(4'h1);
        pulse(4'h2);
        txst(8'hFF, 8'h01, "tx_ok");
        apb(1'b1, TX_STATUS_OFS, 32'hFF);
        rchk(TX_STATUS_OFS, 32'hFF, 32'h01, "tx_ro");
        hb_on <= 1'b0;
        apb(1'b1, TX_CTRL_OFS, 32'h1);
        rchk(TX_STATUS_OFS, 32'hFF, 32'h00, "tx_clear");
        pulse(4'h4);
        pulse(4'h1);
        drop <= 1'b1;
        pulse(4'h2);
        drop <= 1'b0;
        txst(8'hFF, 8'h55, "tx_col_crs");
        hb_on <= 1'b1;
        apb(1'b1, TX_CTRL_OFS, 32'h1);
        pulse(4'h1);
        repeat (520) @(posedge i_clk);
        pulse(4'h4);
        pulse(4'h1);
        pulse(4'h2);
        txst(8'hFF, 8'h85, "tx_late");
        apb(1'b1, TX_CTRL_OFS, 32'h1);
        pulse(4'h1);
        pulse(4'h8);
        txst(8'hBF, 8'h20, "tx_underrun");
        apb(1'b1, TX_CTRL_OFS, 32'h1);
        repeat (16) pulse(4'h4);
        txst(8'hBF, 8'h0C, "tx_excess");
        rchk(COLL_CNT_OFS, 32'h1F, {27'h0, MAX_ATTEMPTS}, "coll_cnt");
        stn = {r[15:0], r[31:1], 1'b0};
        apb(1'b1, STATION_LO_OFS, stn[31:0]);
        apb(1'b1, STATION_HI_OFS, {16'h0, stn[47:32]});
        for (int i = 0; i < 240; i++) begin
            r = lfsr(r);
            if (i % 30 == 0) begin
                cfg = (i == 210) ? 8'h1C : {2'b00, r[15:10]} & (r[15] ? 8'h3E : 8'h3F);
                apb(1'b1, RX_CFG_OFS, {24'h0, cfg});
            end
            @(posedge i_clk);
            i_rx_dest <= r[1:0] == 2'b00 ? 48'hFFFFFFFFFFFF : r[1:0] == 2'b01 ? stn :
                r[1:0] == 2'b10 ? stn ^ {r[20:18], 45'h0} : {r[15:0], r};
            i_rx_len <= 11'h03F + {9'h0, r[4:3]};
            i_rx_crc_err <= r[6] & r[7];
            i_rx_align_err <= r[8] & r[9];
            i_rx_hash_hit <= r[5] | (cfg == 8'h1C);
            i_rx_end <= 1'b1;
            @(posedge i_clk);
            i_rx_end <= 1'b0;
            @(negedge i_clk);
            tally += (want(cfg) == 2'b01) ? 1 : 0;
            chk("rx_filter", {30'h0, want(cfg)}, {30'h0, o_rx_store, o_rx_accept});
        end
        rchk(MISSED_CNT_OFS, 32'hFFFFFFFF, tally, "mon_tally");
        tally_and_finish();
    end
    initial begin
        repeat (90000) @(posedge i_clk);
        n_fail++;
        tally_and_finish();
    end
endmodule // mac_tx_status_rx_filter_tb_top
`default_nettype wire
